// ==== core/operand_address_generation.sv ====
// Operand datapath: effective address, literals and byte lane ordering.
`timescale 1ns/10ps

// Behaviour
// - Triple is twelve bytes, quad sixteen bytes.
// - Support byte, half, word, double, triple, quad.
// - Store puts least significant byte at base.
// - Short loads land LSB in register bit 0.
// - Wide loads fill base register upward.
// - Bit operations on registers only, bit 0 LSB.
// - Ordinal literal zero-extends to operand width.
// - Ordinal literal is a non-negative integer.
// - Only +0.0 and +1.0, floating instructions only.
// - Floating instructions accept ordinal literals elsewhere.
// - Float registers only for floating instructions.
// - Register indirect uses base, optional offset.
// - Index scaled by 1, 2, 4, 8 or 16.
// - Base plus scaled index, optional displacement.
// - Scaled index plus displacement, no base.
// - Instruction pointer plus displacement plus eight.
// - Short offset 0..2047; long signed displacement.
module operand_address_generation
	import operand_pkg::*;
(
	input  wire logic              mclk_in,
	input  wire logic              sys_rst_in,
	// Address request.
	input  wire logic              addr_req_in,
	input  wire addr_mode_t        addr_mode_in,
	input  wire logic [31:0]       abase_in,
	input  wire logic [31:0]       index_in,
	input  wire logic [2:0]        scale_log_in,
	input  wire logic [11:0]       short_ofs_in,
	input  wire logic [31:0]       disp_in,
	input  wire logic [31:0]       instruction_pointer_in,
	input  wire block_size_t       block_size_in,
	output logic                   addr_valid_out,
	output logic [31:0]            eff_addr_out,
	output logic                   addr_fault_out,
	// Literal request.
	input  wire logic              lit_req_in,
	input  wire logic              lit_is_float_in,
	input  wire logic              lit_fp_one_in,
	input  wire logic              instr_is_float_in,
	input  wire op_width_t         op_width_in,
	input  wire logic [4:0]        ord_lit_in,
	output logic                   lit_valid_out,
	output logic [79:0]            lit_value_out,
	output logic                   lit_fault_out,
	// Register operand select check.
	input  wire logic              reg_sel_req_in,
	input  wire logic              reg_sel_float_in,
	output logic                   reg_sel_ok_out,
	// Store lane ordering: register words to memory bytes.
	input  wire logic              store_req_in,
	input  wire logic [127:0]      store_regs_in,
	output logic                   store_valid_out,
	output logic [127:0]           store_bytes_out,
	output logic [15:0]            store_byte_en_out,
	// Load lane ordering: memory bytes to register words.
	input  wire logic              load_req_in,
	input  wire logic [127:0]      load_bytes_in,
	input  wire logic [4:0]        load_base_reg_in,
	output logic                   load_valid_out,
	output logic [127:0]           load_regs_out,
	output logic [3:0]             load_reg_en_out,
	output logic                   load_align_fault_out,
	// Bit operation on a register value.
	input  wire logic              bit_req_in,
	input  wire logic [31:0]       bit_reg_in,
	input  wire logic [4:0]        bit_num_in,
	output logic                   bit_valid_out,
	output logic                   bit_value_out
);

	// Byte count of a block size.
	// A code that is not one-hot falls back to one byte, so a stray size
	// can never enable more lanes than the smallest block would.
	function automatic logic [4:0] block_bytes(input block_size_t sz);
		logic [4:0] n;
		n = 5'h01;
		unique case (sz)
			SIZE_BYTE:   n = 5'h01;
			SIZE_HALF:   n = 5'h02;
			SIZE_WORD:   n = 5'h04;
			SIZE_DOUBLE: n = 5'(DOUBLE_BYTES);
			SIZE_TRIPLE: n = 5'(TRIPLE_BYTES);
			SIZE_QUAD:   n = 5'(QUAD_BYTES);
			default:     n = 5'h01;
		endcase
		return n;
	endfunction : block_bytes

	// Number of register words a block occupies.
	// Sizes up to a word use one register; larger ones count whole words,
	// so the triple size yields three words and the quad size four.
	function automatic logic [2:0] block_words(input block_size_t sz);
		logic [4:0] b;
		b = block_bytes(sz);
		return (b <= 5'h04) ? 3'h1 : 3'(b[4:2]);
	endfunction : block_words

	// Index shifted by the scale exponent, wrapping at 32 bits.
	// An exponent above four is still applied; the caller flags it as a
	// fault rather than silently forcing a legal scale.
	function automatic logic [31:0] scaled(input logic [31:0] idx,
		input logic [2:0] lg);
		return idx << lg;
	endfunction : scaled

	logic [31:0] next_addr;
	logic        next_addr_fault;
	logic [79:0] next_lit;
	logic        next_lit_fault;
	logic [4:0]  ld_bytes;
	logic [2:0]  ld_words;
	logic [4:0]  st_bytes;

	// Effective address; every sum is kept to 32 bits so it wraps.
	// Carries beyond bit 31 are dropped on purpose, so an address near the
	// top of the space wraps to the bottom just as software expects.
	always_comb begin
		next_addr = 32'h0000_0000;
		next_addr_fault = (scale_log_in > SCALE_LOG_MAX);
		unique case (addr_mode_in)
			MODE_ABS_SHORT: next_addr = {20'h00000, short_ofs_in}
				& SHORT_OFS_MAX;
			MODE_ABS_LONG: next_addr = disp_in;
			MODE_REG_IND: next_addr = abase_in;
			MODE_REG_OFS: next_addr = abase_in
				+ {20'h00000, short_ofs_in & SHORT_OFS_MAX[11:0]};
			MODE_REG_DSP: next_addr = abase_in + disp_in;
			MODE_REG_IDX: next_addr = abase_in
				+ scaled(index_in, scale_log_in);
			MODE_REG_IDX_DSP: next_addr = abase_in
				+ scaled(index_in, scale_log_in) + disp_in;
			MODE_IDX_DSP: next_addr = scaled(index_in, scale_log_in)
				+ disp_in;
			MODE_IP_DSP: next_addr = instruction_pointer_in + disp_in
				+ IP_BIAS;
			default: next_addr_fault = 1'b1;
		endcase
		// The scale fault only matters to the index modes; an illegal mode
		// code keeps the fault raised by the default branch.
		if (addr_mode_in inside {MODE_ABS_SHORT, MODE_REG_OFS}) begin
			next_addr_fault = short_ofs_in[11];
		end else if (addr_mode_in inside {MODE_ABS_LONG, MODE_REG_IND,
			MODE_REG_DSP, MODE_IP_DSP}) begin
			next_addr_fault = 1'b0;
		end
	end

	// Literal expansion to the operand width.
	// Positive zero is all zeros in every format, so only positive one
	// needs a per-width encoding.
	always_comb begin
		next_lit = 80'h0;
		next_lit_fault = 1'b0;
		if (lit_is_float_in) begin
			next_lit_fault = !instr_is_float_in;
			if (lit_fp_one_in) begin
				unique case (op_width_in)
					OPW_32:  next_lit = FP_ONE_32;
					OPW_64:  next_lit = FP_ONE_64;
					OPW_80:  next_lit = FP_ONE_80;
					default: next_lit_fault = 1'b1;
				endcase
			end
		end else begin
			next_lit = {75'h0, ord_lit_in};
		end
	end

	// Address result register; an output pulse marks each answer.
	// Address and fault hold their values until the next request, so a
	// slow consumer may read them any time before it asks again.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			addr_valid_out <= 1'b0;
			eff_addr_out   <= 32'h0000_0000;
			addr_fault_out <= 1'b0;
		end else begin
			addr_valid_out <= addr_req_in;
			if (addr_req_in) begin
				eff_addr_out   <= next_addr;
				addr_fault_out <= next_addr_fault;
			end
		end
	end

	// Literal result register.
	// A refused literal is still produced; only the fault flag marks it.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			lit_valid_out <= 1'b0;
			lit_value_out <= 80'h0;
			lit_fault_out <= 1'b0;
		end else begin
			lit_valid_out <= lit_req_in;
			if (lit_req_in) begin
				lit_value_out <= next_lit;
				lit_fault_out <= next_lit_fault;
			end
		end
	end

	// Register selection check, answered in the same cycle.
	// Kept combinational so the decoder can refuse a floating register
	// before the operand fetch is launched.
	always_comb begin
		reg_sel_ok_out = reg_sel_req_in
			&& (!reg_sel_float_in || instr_is_float_in);
	end

	assign st_bytes = block_bytes(block_size_in);
	assign ld_bytes = block_bytes(block_size_in);
	assign ld_words = block_words(block_size_in);

	// Store: register byte k goes to memory byte base+k, so lane k.
	// Lanes beyond the block size still carry register data; only the byte
	// enables decide what the memory side writes.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			store_valid_out   <= 1'b0;
			store_bytes_out   <= 128'h0;
			store_byte_en_out <= 16'h0000;
		end else begin
			store_valid_out <= store_req_in;
			if (store_req_in) begin
				store_bytes_out <= store_regs_in;
				for (int k = 0; k < BLOCK_BYTES; k++) begin
					store_byte_en_out[k] <= (5'(k) < st_bytes);
				end
			end
		end
	end

	// Load: bytes fill registers from bit 0; unused lanes are zero.
	// Zeroing unused lanes keeps stale memory bytes out of the upper words
	// of a short load.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			load_valid_out       <= 1'b0;
			load_regs_out        <= 128'h0;
			load_reg_en_out      <= 4'h0;
			load_align_fault_out <= 1'b0;
		end else begin
			load_valid_out <= load_req_in;
			if (load_req_in) begin
				for (int k = 0; k < BLOCK_BYTES; k++) begin
					load_regs_out[k*8 +: 8] <= (5'(k) < ld_bytes)
						? load_bytes_in[k*8 +: 8] : 8'h00;
				end
				for (int w = 0; w < 4; w++) begin
					load_reg_en_out[w] <= (3'(w) < ld_words);
				end
				unique case (block_size_in)
					SIZE_DOUBLE: load_align_fault_out <=
						load_base_reg_in[0];
					SIZE_TRIPLE, SIZE_QUAD: load_align_fault_out <=
						|load_base_reg_in[1:0];
					default: load_align_fault_out <= 1'b0;
				endcase
			end
		end
	end

	// Bit pick from a register value; memory is never addressed here.
	// The bit number is five bits wide, so every value selects a real bit
	// and no range check is needed.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			bit_valid_out <= 1'b0;
			bit_value_out <= 1'b0;
		end else begin
			bit_valid_out <= bit_req_in;
			if (bit_req_in)
				bit_value_out <= bit_reg_in[bit_num_in];
		end
	end

endmodule : operand_address_generation

// ==== core/operand_pkg.sv ====
// Package of constants and types for the operand address and lane datapath.
package operand_pkg;

	// Addressing modes, one-hot encoded.
	typedef enum logic [8:0] {
		MODE_ABS_SHORT   = 9'h001,
		MODE_ABS_LONG    = 9'h002,
		MODE_REG_IND     = 9'h004,
		MODE_REG_OFS     = 9'h008,
		MODE_REG_IDX     = 9'h010,
		MODE_REG_IDX_DSP = 9'h020,
		MODE_IDX_DSP     = 9'h040,
		MODE_IP_DSP      = 9'h080,
		MODE_REG_DSP     = 9'h100
	} addr_mode_t;

	// Block sizes, one-hot encoded.
	typedef enum logic [5:0] {
		SIZE_BYTE   = 6'h01,
		SIZE_HALF   = 6'h02,
		SIZE_WORD   = 6'h04,
		SIZE_DOUBLE = 6'h08,
		SIZE_TRIPLE = 6'h10,
		SIZE_QUAD   = 6'h20
	} block_size_t;

	// Operand source widths, one-hot encoded.
	typedef enum logic [2:0] {
		OPW_32 = 3'h1,
		OPW_64 = 3'h2,
		OPW_80 = 3'h4
	} op_width_t;

	localparam int ADDR_W = 32;
	localparam int WORD_W = 32;
	localparam int BLOCK_BYTES = 16;
	localparam int TRIPLE_BYTES = 12;
	localparam int QUAD_BYTES = 16;
	localparam int DOUBLE_BYTES = 8;
	localparam int OPERAND_W = 80;
	localparam int SHORT_OFS_W = 12;
	localparam logic [31:0] IP_BIAS = 32'h0000_0008;
	localparam logic [31:0] SHORT_OFS_MAX = 32'h0000_07FF;
	localparam logic [2:0] SCALE_LOG_MAX = 3'h4;
	localparam int REG_NUM_W = 5;

	// Floating-point one encodings per format; zero is all zeros.
	localparam logic [79:0] FP_ONE_32 = 80'h0000_0000_0000_3F80_0000;
	localparam logic [79:0] FP_ONE_64 = 80'h0000_3FF0_0000_0000_0000;
	localparam logic [79:0] FP_ONE_80 = 80'h3FFF_8000_0000_0000_0000;

endpackage : operand_pkg

// ==== tb/mem_partner.sv ====
// Memory image standing at the far side of the load and store lanes.
`timescale 1ns/10ps
module mem_partner (
	input  wire logic         mclk_in,
	input  wire logic         store_valid_in,
	input  wire logic [127:0] store_bytes_in,
	input  wire logic [15:0]  store_byte_en_in,
	output logic [127:0]      mem_bytes_out
);
	// Filler so that unused lanes never read back as zero by chance.
	initial mem_bytes_out = {16{8'hA5}};
	// lane k at base plus k
	always @(posedge mclk_in) begin
		for (int k = 0; k < 16; k++) begin
			if (store_valid_in && store_byte_en_in[k]) begin
				mem_bytes_out[8*k +: 8] <= store_bytes_in[8*k +: 8];
			end
		end
	end
endmodule : mem_partner

// ==== tb/oag_monitor.sv ====
// Checker of port relations for the operand datapath.
`timescale 1ns/10ps
module oag_monitor
	import operand_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        addr_req_in,
	input  wire addr_mode_t  addr_mode_in,
	input  wire logic [31:0] abase_in,
	input  wire logic [31:0] index_in,
	input  wire logic [2:0]  scale_log_in,
	input  wire logic [31:0] disp_in,
	input  wire logic [31:0] instruction_pointer_in,
	input  wire logic        addr_valid_out,
	input  wire logic [31:0] eff_addr_out,
	input  wire logic        lit_req_in,
	input  wire logic        lit_is_float_in,
	input  wire logic        instr_is_float_in,
	input  wire logic [4:0]  ord_lit_in,
	input  wire logic        lit_valid_out,
	input  wire logic [79:0] lit_value_out,
	input  wire logic        lit_fault_out,
	input  wire logic        reg_sel_req_in,
	input  wire logic        reg_sel_float_in,
	input  wire logic        reg_sel_ok_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	// An address request of one mode, taken on this edge.
	sequence s_mode(addr_mode_t m);
		addr_req_in && addr_mode_in == m;
	endsequence
	// The answer is a one-cycle pulse tied to each taken request.
	chk_addr_answer: assert property (addr_req_in |=> addr_valid_out)
		else $error("address answer missing");
	chk_addr_quiet: assert property (!addr_req_in |=> !addr_valid_out)
		else $error("address answer without request");
	chk_reg_ind: assert property (s_mode(MODE_REG_IND) |=>
		eff_addr_out == $past(abase_in)) else $error("indirect address wrong");
	chk_ip_rel: assert property (s_mode(MODE_IP_DSP) |=> eff_addr_out ==
		$past(instruction_pointer_in) + $past(disp_in) + IP_BIAS)
		else $error("pointer relative address wrong");
	// Here only legal scales are compared; illegal ones raise a fault instead. The next check compares every scale.
	chk_idx_disp: assert property (s_mode(MODE_IDX_DSP) ##0
		scale_log_in <= SCALE_LOG_MAX |=> eff_addr_out ==
		($past(index_in) << $past(scale_log_in)) + $past(disp_in))
		else $error("index displacement address wrong");
	chk_base_idx_dsp: assert property (s_mode(MODE_REG_IDX_DSP) |=>
		eff_addr_out == $past(abase_in) + $past(disp_in) +
		($past(index_in) << $past(scale_log_in)))
		else $error("base index displacement address wrong");
	chk_ord_extend: assert property (lit_req_in && !lit_is_float_in |=>
		lit_value_out == {75'h0, $past(ord_lit_in)} && !lit_fault_out)
		else $error("ordinal literal not zero extended");
	chk_float_refuse: assert property (lit_req_in && lit_is_float_in &&
		!instr_is_float_in |=> lit_valid_out && lit_fault_out)
		else $error("float literal accepted outside float instruction");
	chk_plain_reg_ok: assert property (reg_sel_req_in && !reg_sel_float_in
		|-> reg_sel_ok_out) else $error("plain register refused");
endmodule : oag_monitor
bind operand_address_generation oag_monitor oag_monitor_inst (.*);

// ==== tb/tb_top.sv ====
// Self-checking bench for the operand datapath.
`timescale 1ns/10ps
module tb_top;
	import operand_pkg::*;
	logic         mclk_in = 1'b0, sys_rst_in = 1'b1;
	logic         addr_req_in = 1'b0, lit_req_in = 1'b0, bit_req_in = 1'b0;
	logic         store_req_in = 1'b0, load_req_in = 1'b0;
	logic         reg_sel_req_in = 1'b0, reg_sel_float_in = 1'b0;
	logic         lit_is_float_in = 1'b0, lit_fp_one_in = 1'b0;
	logic         instr_is_float_in = 1'b0;
	addr_mode_t   addr_mode_in = MODE_REG_IND;
	block_size_t  block_size_in = SIZE_WORD;
	op_width_t    op_width_in = OPW_32;
	logic [31:0]  abase_in = '0, index_in = '0, disp_in = '0, bit_reg_in = '0;
	logic [31:0]  instruction_pointer_in = 32'h0000_1000;
	logic [2:0]   scale_log_in = '0;
	logic [11:0]  short_ofs_in = '0;
	logic [4:0]   ord_lit_in = '0, load_base_reg_in = '0, bit_num_in = '0;
	logic [127:0] store_regs_in = '0, load_bytes_in, store_bytes_out;
	logic [127:0] load_regs_out;
	logic         addr_valid_out, addr_fault_out, lit_valid_out, lit_fault_out;
	logic         reg_sel_ok_out, store_valid_out, load_valid_out;
	logic         load_align_fault_out, bit_valid_out, bit_value_out;
	logic [31:0]  eff_addr_out;
	logic [79:0]  lit_value_out;
	logic [15:0]  store_byte_en_out;
	logic [3:0]   load_reg_en_out;
	int           bad_count = 0, compares = 0;
	always #10 mclk_in = ~mclk_in;
	operand_address_generation operand_address_generation_inst (.*);
	mem_partner mem_partner_inst (.mclk_in(mclk_in),
		.store_valid_in(store_valid_out), .store_bytes_in(store_bytes_out),
		.store_byte_en_in(store_byte_en_out), .mem_bytes_out(load_bytes_in));
	task automatic chk(string what, logic [127:0] ex, logic [127:0] got);
		compares++;
		if (got !== ex) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, ex, got);
		end
	endtask : chk
	// Lets the taking edge pass, drops the address, literal, store, load and bit requests, then waits to settle.
	task automatic fire;
		@(posedge mclk_in);
		{addr_req_in, lit_req_in, store_req_in, load_req_in, bit_req_in} <= '0;
		#1;
	endtask : fire
	task automatic addr(addr_mode_t m, logic [31:0] ab, ix, dp,
			logic [2:0] sc, logic [11:0] so, logic [31:0] ex, logic f);
		@(posedge mclk_in);
		addr_req_in <= 1'b1;
		addr_mode_in <= m;
		{abase_in, index_in, disp_in} <= {ab, ix, dp};
		{scale_log_in, short_ofs_in} <= {sc, so};
		fire;
		chk("addr_valid", 1'b1, addr_valid_out);
		chk("eff_addr", ex, eff_addr_out);
		chk("addr_fault", f, addr_fault_out);
	endtask : addr
	// Offset and displacement carry equal values where a mode may use either.
	task automatic t_modes;
		addr(MODE_ABS_SHORT, '0, '0, '0, '0, 12'h7FF, 32'h7FF, 0);
		addr(MODE_ABS_LONG, '0, '0, 32'hFFFF_FF00, '0, '0, 32'hFFFF_FF00, 0);
		addr(MODE_REG_IND, 32'h1234_5678, '0, '0, '0, '0, 32'h1234_5678, 0);
		addr(MODE_REG_OFS, 32'h100, '0, 32'h10, '0, 12'h010, 32'h110, 0);
		addr(MODE_REG_IDX, 32'h100, 32'h3, '0, 3'h4, '0, 32'h130, 0);
		addr(MODE_REG_IDX_DSP, 32'h100, 32'h3, 32'h5, 3'h3, '0, 32'h11D, 0);
		addr(MODE_IP_DSP, '0, '0, 32'h4, '0, '0, 32'h100C, 0);
		addr(MODE_REG_DSP, 32'hFFFF_FFF0, '0, 32'h20, '0, '0, 32'h10, 0);
		for (int s = 0; s < 5; s++) begin
			addr(MODE_IDX_DSP, 32'h100, 32'h3, 32'h1, 3'(s), '0, (32'h3 << s) + 32'h1, 0);
		end
		addr(MODE_IDX_DSP, 32'h100, 32'h1, '0, 3'h5, '0, 32'h20, 1);
	endtask : t_modes
	task automatic lit(logic fl, one, ifl, op_width_t w, logic [79:0] ex, logic f);
		@(posedge mclk_in);
		lit_req_in <= 1'b1;
		{lit_is_float_in, lit_fp_one_in, instr_is_float_in} <= {fl, one, ifl};
		op_width_in <= w;
		ord_lit_in <= 5'h1F;
		fire;
		chk("lit_valid", 1'b1, lit_valid_out);
		chk("lit_value", ex, lit_value_out);
		chk("lit_fault", f, lit_fault_out);
	endtask : lit
	task automatic t_lits;
		lit(0, 0, 0, OPW_80, 80'h1F, 0);
		lit(0, 0, 1, OPW_32, 80'h1F, 0);
		lit(1, 1, 1, OPW_32, FP_ONE_32, 0);
		lit(1, 1, 1, OPW_64, FP_ONE_64, 0);
		lit(1, 1, 1, OPW_80, FP_ONE_80, 0);
		lit(1, 0, 1, OPW_64, 80'h0, 0);
		lit(1, 1, 0, OPW_32, FP_ONE_32, 1);
	endtask : t_lits
	task automatic t_regsel;
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk_in);
			{reg_sel_req_in, reg_sel_float_in, instr_is_float_in} <= {1'b1, i[0], i[1]};
			#1;
			chk("reg_sel_ok", !(i[0] && !i[1]), reg_sel_ok_out);
		end
		@(posedge mclk_in);
		reg_sel_req_in <= 1'b0;
	endtask : t_regsel
	// Each size is stored through the partner, then loaded back from it.
	task automatic t_lanes;
		block_size_t sz[6] = '{SIZE_BYTE, SIZE_HALF, SIZE_WORD, SIZE_DOUBLE,
			SIZE_TRIPLE, SIZE_QUAD};
		int nb[6] = '{1, 2, 4, 8, 12, 16};
		logic [3:0] re[6] = '{4'h1, 4'h1, 4'h1, 4'h3, 4'h7, 4'hF};
		logic [127:0] pat, msk;
		for (int i = 0; i < 6; i++) begin
			pat = 128'h0F0E_0D0C_0B0A_0908_0706_0504_0302_0100 | {16{4'(i + 1), 4'h0}};
			msk = (128'h1 << (8 * nb[i])) - 128'h1;
			@(posedge mclk_in);
			{store_req_in, store_regs_in} <= {1'b1, pat};
			block_size_in <= sz[i];
			fire;
			chk("store_valid", 1'b1, store_valid_out);
			chk("store_en", 16'((32'h1 << nb[i]) - 32'h1),
				store_byte_en_out);
			chk("store_bytes", pat & msk, store_bytes_out & msk);
			@(posedge mclk_in);
			{load_req_in, load_base_reg_in} <= {1'b1, 5'h8};
			fire;
			chk("load_valid", 1'b1, load_valid_out);
			chk("load_regs", pat & msk, load_regs_out);
			chk("load_reg_en", re[i], load_reg_en_out);
			chk("load_align", 1'b0, load_align_fault_out);
		end
		@(posedge mclk_in);
		{load_req_in, load_base_reg_in} <= {1'b1, 5'h9};
		block_size_in <= SIZE_DOUBLE;
		fire;
		chk("load_align", 1'b1, load_align_fault_out);
	endtask : t_lanes
	task automatic t_bits;
		for (int i = 0; i < 3; i++) begin
			@(posedge mclk_in);
			{bit_req_in, bit_reg_in, bit_num_in} <= {1'b1, 32'h8000_0001, 5'(i * 15 + i / 2)};
			fire;
			chk("bit_valid", 1'b1, bit_valid_out);
			chk("bit_value", i != 1, bit_value_out);
		end
	endtask : t_bits
	task automatic tally_and_finish;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (3) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		t_modes;
		t_lits;
		t_regsel;
		t_lanes;
		t_bits;
		tally_and_finish;
	end
	// The tests need well under a thousand cycles; this cuts a hang short.
	initial begin
		#100000;
		bad_count++;
		tally_and_finish;
	end
endmodule : tb_top
